// file: core/ebgp_pkg.sv
// Purpose: Shared constants and types for the expansion-bus GPIO ports
// Assumes: Register offsets are byte addresses on the internal bus
// Notes:   Index 0 is the first 8-bit port, 1 the second, 2 the 6-bit port
package ebgp_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int ADDR_W = 28;
  localparam int DATA_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam int NUM_PORTS = 3;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] PORT_FOUR_DATA_OFS = 28'hffff008;
  localparam logic [ADDR_W-1:0] PORT_FIVE_DATA_OFS = 28'hffff00a;
  localparam logic [ADDR_W-1:0] PORT_SIX_DATA_OFS = 28'hffff00c;
  localparam logic [ADDR_W-1:0] PORT_FOUR_DIRECTION_OFS = 28'hffff028;
  localparam logic [ADDR_W-1:0] PORT_FIVE_DIRECTION_OFS = 28'hffff02a;
  localparam logic [ADDR_W-1:0] PORT_SIX_DIRECTION_OFS = 28'hffff02c;

  localparam logic [ADDR_W-1:0] DATA_OFS [NUM_PORTS] = '{
    PORT_FOUR_DATA_OFS, PORT_FIVE_DATA_OFS, PORT_SIX_DATA_OFS};
  localparam logic [ADDR_W-1:0] DIR_OFS [NUM_PORTS] = '{
    PORT_FOUR_DIRECTION_OFS, PORT_FIVE_DIRECTION_OFS,
    PORT_SIX_DIRECTION_OFS};

  // ************************************************************
  // Reset values and implemented bits
  // ************************************************************
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET_WIDE = 8'hff;
  localparam logic [DATA_W-1:0] DIR_RESET_NARROW = 8'h3f;
  localparam logic [DATA_W-1:0] DIR_RESET [NUM_PORTS] = '{
    DIR_RESET_WIDE, DIR_RESET_WIDE, DIR_RESET_NARROW};
  localparam logic [DATA_W-1:0] PORT_MASK [NUM_PORTS] = '{
    8'hff, 8'hff, 8'h3f};
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // Direction bit encoding
  localparam logic DIR_OUTPUT = 1'b0;
  localparam logic DIR_INPUT = 1'b1;

  // ************************************************************
  // Carriers
  // ************************************************************
  // One bit per pin of the three ports
  typedef struct packed {
    logic [7:0] four;
    logic [7:0] five;
    logic [5:0] six;
  } ebgp_pins_t;

  // Drive offered by the expansion bus controller
  typedef struct packed {
    logic [15:0] adOut;
    logic [15:0] adOe;
    logic [5:0] upperAddr;
  } ebgp_expbus_t;

endpackage : ebgp_pkg

// file: core/ebgp_gpio_ports.sv
// Purpose: Data latches, direction registers and pin drivers for
//          two 8-bit ports and one 6-bit port shared with the
//          external memory expansion bus
// Assumes: Pins are sampled synchronously to sys_clk by the caller
// Notes:   Register reads answer in the cycle after the read strobe
`timescale 1ns/1ps

// Overview of operation
// - Two 8-bit ports, per-bit direction
// - 6-bit port, bits 6 and 7 zero
// - Direction 0 output, 1 input
// - Output pin follows its latch bit
// - Input mode: read pin, write latch only
// - Output mode: read latch, write drives pin
// - Reset makes every pin an input except those an alternate mode selects
// - Direction registers allow byte and bit access
// - Address/data bus mode keeps direction registers
// - Upper address mode keeps direction register
// - No pull-up control anywhere
module ebgp_gpio_ports #(
  parameter int PORT_WIDE_W = 8,
  parameter int PORT_NARROW_W = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [ebgp_pkg::ADDR_W-1:0] busAddr,
  input wire logic [ebgp_pkg::DATA_W-1:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic busBitAccess,
  input wire logic [ebgp_pkg::BIT_SEL_W-1:0] busBitSel,
  output logic [ebgp_pkg::DATA_W-1:0] busRdData,
  // Pins, split into input, output and output enable
  input wire ebgp_pkg::ebgp_pins_t pinIn,
  output ebgp_pkg::ebgp_pins_t pinOut,
  output ebgp_pkg::ebgp_pins_t pinOe,
  // Alternate function selection and drive
  input wire logic adBusSelect,
  input wire logic [PORT_NARROW_W-1:0] upperAddrSelect,
  input wire ebgp_pkg::ebgp_expbus_t expBus
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [ebgp_pkg::DATA_W-1:0] latch [ebgp_pkg::NUM_PORTS];
  logic [ebgp_pkg::DATA_W-1:0] dir [ebgp_pkg::NUM_PORTS];
  logic [ebgp_pkg::DATA_W-1:0] pinWord [ebgp_pkg::NUM_PORTS];
  logic [ebgp_pkg::DATA_W-1:0] portView [ebgp_pkg::NUM_PORTS];
  logic [ebgp_pkg::NUM_PORTS-1:0] dataHit;
  logic [ebgp_pkg::NUM_PORTS-1:0] dirHit;
  logic [ebgp_pkg::DATA_W-1:0] next_busRdData;
  logic [ebgp_pkg::NUM_PORTS-1:0] dataWrEn;
  logic [ebgp_pkg::NUM_PORTS-1:0] dirWrEn;
  logic [ebgp_pkg::DATA_W-1:0] writeMask;
  logic [ebgp_pkg::DATA_W-1:0] writeWord;
  logic [ebgp_pkg::DATA_W-1:0] gpioOut [ebgp_pkg::NUM_PORTS];
  logic [ebgp_pkg::DATA_W-1:0] gpioOe [ebgp_pkg::NUM_PORTS];
  logic [ebgp_pkg::DATA_W-1:0] altOut [ebgp_pkg::NUM_PORTS];
  logic [ebgp_pkg::DATA_W-1:0] altOe [ebgp_pkg::NUM_PORTS];
  logic [ebgp_pkg::DATA_W-1:0] altSel [ebgp_pkg::NUM_PORTS];
  logic [ebgp_pkg::DATA_W-1:0] driveOut [ebgp_pkg::NUM_PORTS];
  logic [ebgp_pkg::DATA_W-1:0] driveOe [ebgp_pkg::NUM_PORTS];

  // ************************************************************
  // Pin sampling and register view
  // ************************************************************
  // Gather pins into byte lanes; absent bits of the 6-bit port are 0
  always_comb begin
    pinWord[0] = pinIn.four;
    pinWord[1] = pinIn.five;
    pinWord[2] = {2'h0, pinIn.six} & ebgp_pkg::PORT_MASK[2];
  end

  // Input bits show the pin, output bits show the latch
  always_comb begin
    for (int i = 0; i < ebgp_pkg::NUM_PORTS; i++) begin
      portView[i] = ((dir[i] & pinWord[i]) | (~dir[i] & latch[i]))
                    & ebgp_pkg::PORT_MASK[i];
    end
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  // Only the six documented offsets answer; no pull-up register exists
  always_comb begin
    for (int i = 0; i < ebgp_pkg::NUM_PORTS; i++) begin
      dataHit[i] = (busAddr == ebgp_pkg::DATA_OFS[i]);
      dirHit[i] = (busAddr == ebgp_pkg::DIR_OFS[i]);
    end
  end

  // ************************************************************
  // Write qualification
  // ************************************************************
  // One enable per register; a strobe elsewhere changes nothing
  always_comb begin
    for (int i = 0; i < ebgp_pkg::NUM_PORTS; i++) begin
      dataWrEn[i] = busWrite && dataHit[i];
      dirWrEn[i] = busWrite && dirHit[i];
    end
  end

  // A bit access touches only the named bit and takes data bit 0
  always_comb begin
    writeMask = ebgp_pkg::READ_ZERO;
    writeWord = busWrData;
    if (busBitAccess) begin
      writeMask[busBitSel] = 1'b1;
      writeWord = {ebgp_pkg::DATA_W{busWrData[0]}};
    end else begin
      writeMask = ~ebgp_pkg::READ_ZERO;
    end
  end

  // Merge the qualified write into an old byte, absent bits stay 0
  function automatic logic [ebgp_pkg::DATA_W-1:0] merge_write(
    input logic [ebgp_pkg::DATA_W-1:0] old,
    input logic [ebgp_pkg::DATA_W-1:0] mask
  );
    return ((old & ~writeMask) | (writeWord & writeMask)) & mask;
  endfunction : merge_write

  // ************************************************************
  // Data latches
  // ************************************************************
  // A write always lands in the latch, whatever the direction
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < ebgp_pkg::NUM_PORTS; i++) begin
        latch[i] <= ebgp_pkg::DATA_RESET;
      end
    end else begin
      for (int i = 0; i < ebgp_pkg::NUM_PORTS; i++) begin
        if (dataWrEn[i]) begin
          latch[i] <= merge_write(latch[i],
                                  ebgp_pkg::PORT_MASK[i]);
        end
      end
    end
  end

  // ************************************************************
  // Direction registers
  // ************************************************************
  // Reset sets every direction bit to input; alternate modes never touch these
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < ebgp_pkg::NUM_PORTS; i++) begin
        dir[i] <= ebgp_pkg::DIR_RESET[i];
      end
    end else begin
      for (int i = 0; i < ebgp_pkg::NUM_PORTS; i++) begin
        if (dirWrEn[i]) begin
          dir[i] <= merge_write(dir[i],
                                ebgp_pkg::PORT_MASK[i]);
        end
      end
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Select the addressed byte, or one bit of it for a bit read
  always_comb begin
    logic [ebgp_pkg::DATA_W-1:0] sel;
    sel = ebgp_pkg::READ_ZERO;
    for (int i = 0; i < ebgp_pkg::NUM_PORTS; i++) begin
      if (dataHit[i]) begin
        sel = portView[i];
      end
      if (dirHit[i]) begin
        sel = dir[i];
      end
    end
    if (busBitAccess) begin
      next_busRdData = {7'h00, sel[busBitSel]};
    end else begin
      next_busRdData = sel;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busRdData <= ebgp_pkg::READ_ZERO;
    end else if (busRead) begin
      busRdData <= next_busRdData;
    end else begin
      busRdData <= ebgp_pkg::READ_ZERO;
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  // Port drive from the latch and direction registers
  always_comb begin
    for (int i = 0; i < ebgp_pkg::NUM_PORTS; i++) begin
      gpioOut[i] = latch[i] & ebgp_pkg::PORT_MASK[i];
      gpioOe[i] = ~dir[i] & ebgp_pkg::PORT_MASK[i];
    end
  end

  // Drive offered by the bus controller, in the same byte lanes
  always_comb begin
    altOut[0] = expBus.adOut[7:0];
    altOut[1] = expBus.adOut[15:8];
    altOut[2] = {2'h0, expBus.upperAddr};
    altOe[0] = expBus.adOe[7:0];
    altOe[1] = expBus.adOe[15:8];
    altOe[2] = ebgp_pkg::PORT_MASK[2]; // Upper address always driven
  end

  // Which pins the bus controller owns; address/data takes whole ports
  always_comb begin
    altSel[0] = {ebgp_pkg::DATA_W{adBusSelect}};
    altSel[1] = {ebgp_pkg::DATA_W{adBusSelect}};
    altSel[2] = ebgp_pkg::READ_ZERO;
    altSel[2][PORT_NARROW_W-1:0] = upperAddrSelect;
  end

  // Each pin bit picks its owner; direction registers stay untouched
  for (genvar p = 0; p < ebgp_pkg::NUM_PORTS; p++) begin : g_port
    for (genvar b = 0; b < ebgp_pkg::DATA_W; b++) begin : g_bit
      assign driveOut[p][b] = altSel[p][b] ? altOut[p][b] : gpioOut[p][b];
      assign driveOe[p][b] = altSel[p][b] ? altOe[p][b] : gpioOe[p][b];
    end
  end

  // Fold the byte lanes back onto the pin structs
  always_comb begin
    pinOut.four = driveOut[0];
    pinOut.five = driveOut[1];
    pinOut.six = driveOut[2][PORT_NARROW_W-1:0];
    pinOe.four = driveOe[0];
    pinOe.five = driveOe[1];
    pinOe.six = driveOe[2][PORT_NARROW_W-1:0];
  end

endmodule : ebgp_gpio_ports

// file: dv/ebgp_pins_model.sv
// Purpose: Far side of the port pins, outside levels meet device drive
// Assumes: Outside always drives a level, no resistor holds the line
// Notes:   Bus controller drive comes straight from the bench
`timescale 1ns/1ps
module ebgp_pins_model (
  // Device drive
  input wire ebgp_pkg::ebgp_pins_t pinOut,
  input wire ebgp_pkg::ebgp_pins_t pinOe,
  // Outside drive and resolved levels
  input wire ebgp_pkg::ebgp_pins_t extDrive,
  output ebgp_pkg::ebgp_pins_t pinIn
);
  // Driven wires show the device level, others the outside level
  assign pinIn = (pinOut & pinOe) | (extDrive & ~pinOe);
endmodule : ebgp_pins_model

// file: dv/ebgp_gpio_ports_chk.sv
// Purpose: Port level checks for the expansion-bus GPIO ports
// Assumes: One clock domain, read data one cycle after the strobe
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module ebgp_gpio_ports_chk #(parameter int PORT_NARROW_W = 6) (
  // Clock, reset and register port
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [27:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic busBitAccess,
  input wire logic [2:0] busBitSel,
  input wire logic [7:0] busRdData,
  // Pins and alternate function
  input wire ebgp_pkg::ebgp_pins_t pinIn,
  input wire ebgp_pkg::ebgp_pins_t pinOut,
  input wire ebgp_pkg::ebgp_pins_t pinOe,
  input wire logic adBusSelect,
  input wire logic [PORT_NARROW_W-1:0] upperAddrSelect,
  input wire ebgp_pkg::ebgp_expbus_t expBus
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Read view of the first port and byte write qualifier
  logic [7:0] view;
  logic byteWr;
  assign view = (pinIn.four & ~pinOe.four) | (pinOut.four & pinOe.four);
  assign byteWr = busWrite && !busBitAccess;
  a_reset_inputs: assert property ($past(sys_rst) && !adBusSelect
    && upperAddrSelect == '0 |-> pinOe == '0) else $error("Pin driven");
  a_read_view: assert property (
    busRead && !busBitAccess && !adBusSelect && busAddr ==
    ebgp_pkg::PORT_FOUR_DATA_OFS |=> busRdData == $past(view))
    else $error("Bad read");
  a_dir_drives: assert property (
    byteWr && busAddr == ebgp_pkg::PORT_FOUR_DIRECTION_OFS
    |=> adBusSelect || pinOe.four == ~$past(busWrData)) else $error("Bad oe");
  a_latch_drives: assert property (
    byteWr && busAddr == ebgp_pkg::PORT_FOUR_DATA_OFS |=> adBusSelect
    || ((pinOut.four ^ $past(busWrData)) & pinOe.four) == '0)
    else $error("Bad out");
  a_ad_mux: assert property (adBusSelect |->
    {pinOut.five, pinOut.four} == expBus.adOut
    && {pinOe.five, pinOe.four} == expBus.adOe) else $error("Bad ad bus");
  a_upper_mux: assert property (
    (pinOe.six & upperAddrSelect) == upperAddrSelect && ((pinOut.six ^
    expBus.upperAddr) & upperAddrSelect) == '0) else $error("Bad upper");
  a_unmapped_zero: assert property ($past(busRead) && !($past(busAddr)
    inside {ebgp_pkg::DATA_OFS, ebgp_pkg::DIR_OFS}) |-> busRdData == '0)
    else $error("Unmapped read");
  a_bit_read: assert property ($past(busRead) && $past(busBitAccess)
    |-> busRdData[7:1] == '0) else $error("Bad bit read");
endmodule : ebgp_gpio_ports_chk

// file: dv/tb_ebgp_gpio_ports.sv
// Purpose: Self-checking bench for the expansion-bus GPIO ports
// Assumes: Pins resolved by ebgp_pins_model
// Notes:   Table rows first, then reset, bit access and alternate modes
`timescale 1ns/1ps
module tb_ebgp_gpio_ports;
  typedef struct packed {
    logic [1:0] port;
    logic [7:0] dir, lat, ext, exp;
  } ebgp_row_t;
  localparam ebgp_row_t ROWS [4] = '{'{2'h0, 8'h0f, 8'ha5, 8'h3c, 8'hac},
    '{2'h1, 8'hf0, 8'h5a, 8'hc3, 8'hca}, '{2'h2, 8'h15, 8'hff, 8'h2a, 8'h2a},
    '{2'h0, 8'h00, 8'h3c, 8'hc3, 8'h3c}};
  logic sys_clk = 1'b0, sys_rst = 1'b1, busWrite = 1'b0, busRead = 1'b0;
  logic busBitAccess = 1'b0, adBusSelect = 1'b0;
  logic [27:0] busAddr = '0;
  logic [7:0] busWrData = '0, busRdData, d;
  logic [2:0] busBitSel = '0;
  logic [5:0] upperAddrSelect = '0;
  ebgp_pkg::ebgp_pins_t pinIn, pinOut, pinOe, extDrive = '0;
  ebgp_pkg::ebgp_expbus_t expBus = '0;
  int errCount = 0, numChecks = 0, cycles = 0;
  ebgp_gpio_ports ebgp_gpio_ports_inst (.sys_clk, .sys_rst, .busAddr,
    .busWrData, .busWrite, .busRead, .busBitAccess, .busBitSel, .busRdData,
    .pinIn, .pinOut, .pinOe, .adBusSelect, .upperAddrSelect, .expBus);
  ebgp_pins_model ebgp_pins_model_inst (.pinOut, .pinOe, .extDrive, .pinIn);
  // Clock and hang guard
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errCount = errCount + 1;
      wrapUp();
    end
  end
  // One register access; read data land in d
  task automatic acc(input logic w, input logic [27:0] a,
    input logic [7:0] v, input logic b, input logic [2:0] s);
    @(posedge sys_clk);
    busAddr <= a;
    busWrData <= v;
    busBitAccess <= b;
    busBitSel <= s;
    busWrite <= w;
    busRead <= !w;
    @(posedge sys_clk);
    busWrite <= 1'b0;
    busRead <= 1'b0;
    @(posedge sys_clk);
    d = busRdData;
  endtask : acc
  task automatic rd(input logic [27:0] a);
    acc(1'b0, a, 8'h00, 1'b0, 3'h0);
  endtask : rd
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks = numChecks + 1;
    if (seen !== exp) begin
      errCount = errCount + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] pick(ebgp_pkg::ebgp_pins_t p, int i);
    return (i == 0) ? p.four : (i == 1) ? p.five : {2'h0, p.six};
  endfunction : pick
  task automatic wrapUp();
    $display("Checks %0d, mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrapUp
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (ROWS[i]) begin
      acc(1'b1, ebgp_pkg::DIR_OFS[ROWS[i].port], ROWS[i].dir, 1'b0, 3'h0);
      acc(1'b1, ebgp_pkg::DATA_OFS[ROWS[i].port], ROWS[i].lat, 1'b0, 3'h0);
      if (ROWS[i].port == 2'h0) extDrive.four <= ROWS[i].ext;
      else if (ROWS[i].port == 2'h1) extDrive.five <= ROWS[i].ext;
      else extDrive.six <= ROWS[i].ext[5:0];
      rd(ebgp_pkg::DATA_OFS[ROWS[i].port]);
      check(d, ROWS[i].exp);
      check(pick(pinOe, ROWS[i].port),
        ~ROWS[i].dir & ebgp_pkg::PORT_MASK[ROWS[i].port]);
    end
    // Second reset in mid-run brings back inputs and reset values
    sys_rst <= 1'b1;
    extDrive <= '0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd(ebgp_pkg::DATA_OFS[i]);
      check(d, ebgp_pkg::DATA_RESET);
      rd(ebgp_pkg::DIR_OFS[i]);
      check(d, ebgp_pkg::DIR_RESET[i]);
    end
    check(pinOe, '0);
    // Bit access, missing bits and an unmapped place
    acc(1'b1, ebgp_pkg::DIR_OFS[0], 8'h00, 1'b1, 3'h3);
    rd(ebgp_pkg::DIR_OFS[0]);
    check(d, 8'hf7);
    acc(1'b0, ebgp_pkg::DIR_OFS[0], 8'h00, 1'b1, 3'h2);
    check(d, 8'h01);
    acc(1'b1, ebgp_pkg::DIR_OFS[2], 8'h01, 1'b1, 3'h7);
    rd(ebgp_pkg::DIR_OFS[2]);
    check(d, 8'h3f);
    acc(1'b1, 28'hffff088, 8'hff, 1'b0, 3'h0);
    rd(28'hffff088);
    check(d, 8'h00);
    // Alternate bus functions take the pins, direction kept
    expBus <= '{16'h1234, 16'hff0f, 6'h15};
    adBusSelect <= 1'b1;
    upperAddrSelect <= 6'h3f;
    @(posedge sys_clk);
    check({pinOut.five, pinOut.four}, 16'h1234);
    check({pinOe.five, pinOe.four, pinOe.six}, 22'h3fc3ff);
    check(pinOut.six, 6'h15);
    adBusSelect <= 1'b0;
    upperAddrSelect <= 6'h00;
    rd(ebgp_pkg::DIR_OFS[0]);
    check(d, 8'hf7);
    rd(ebgp_pkg::DIR_OFS[2]);
    check(d, 8'h3f);
    wrapUp();
  end
endmodule : tb_ebgp_gpio_ports
bind ebgp_gpio_ports ebgp_gpio_ports_chk #(.PORT_NARROW_W(PORT_NARROW_W))
  ebgp_gpio_ports_chk_inst (.sys_clk, .sys_rst, .busAddr, .busWrData,
  .busWrite, .busRead, .busBitAccess, .busBitSel, .busRdData, .pinIn,
  .pinOut, .pinOe, .adBusSelect, .upperAddrSelect, .expBus);
